/* File: hdl/fmdt_chan.sv */
module fmdt_chan (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic twos,
    input wire logic [7:0] temp,
    input wire logic start_wr,
    input wire logic [7:0] start_wdata,
    input wire logic [7:0] target,
    input wire fmdt_pkg::fmdt_lim_s lim,
    input wire logic [7:0] min_duty,
    input wire logic dyn_en,
    input wire logic dyn_step,
    output logic [7:0] duty,
    output logic [7:0] start_now,
    output logic below_low,
    output logic above_high
);
    logic [7:0] start_reg;
    logic [7:0] start_prog_reg;
    logic fan_on_reg;
    logic [7:0] t_o, s_o, tgt_o, off_o;
    logic [15:0] ramp;
    logic [8:0] sum;

    // Orders codes so unsigned compare works for either encoding
    function automatic logic [7:0] ord(input logic [7:0] v, input logic tw);
        ord = tw ? (v ^ 8'h80) : v;
    endfunction

    assign t_o = ord(temp, twos);
    assign s_o = ord(start_reg, twos);
    assign tgt_o = ord(target, twos);
    assign off_o = s_o - lim.turn_off_hysteresis;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start_reg <= fmdt_pkg::RST_START;
            start_prog_reg <= fmdt_pkg::RST_START;
        end else if (ce) begin
            if (start_wr) begin
                start_reg <= start_wdata;
                start_prog_reg <= start_wdata;
            end else if (dyn_en && dyn_step) begin // R2
                if (t_o > tgt_o && s_o > ord(lim.dynamic_floor, twos)) begin
                    start_reg <= start_reg - 8'h01; // R22
                end else if (t_o < tgt_o && s_o < ord(start_prog_reg, twos)) begin
                    start_reg <= start_reg + 8'h01; // R22
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fan_on_reg <= 1'b0;
        end else if (ce) begin
            if (t_o >= s_o) begin
                fan_on_reg <= 1'b1; // R7
            end else if (t_o < off_o || off_o > s_o) begin
                fan_on_reg <= 1'b0; // R20
            end
        end
    end

    // Duty climbs from the minimum over 2^(span+1) degrees
    assign ramp = (16'(t_o - s_o) * 16'(8'hFF - min_duty))
        >> (4'(lim.control_slope_span) + 4'd1); // R8
    assign sum = {1'b0, min_duty} + ((t_o >= s_o) ? 9'(ramp[7:0]) : 9'h000);

    always_comb begin
        if (!fan_on_reg) begin
            duty = 8'h00;
        end else if (t_o >= s_o && (ramp[15:8] != 8'h00 || sum[8])) begin
            duty = fmdt_pkg::FULL_DUTY;
        end else begin
            duty = sum[7:0];
        end
    end

    assign start_now = start_reg; // R19
    assign below_low = t_o < ord(lim.low_temperature_limit, twos);
    assign above_high = t_o > ord(lim.high_temperature_limit, twos);

    AST_DYN_LOWERS: assert property (@(posedge core_clk) disable iff (rst) // R22
        ce && dyn_en && dyn_step && !start_wr && t_o > tgt_o
        && s_o > ord(lim.dynamic_floor, twos) |=> start_reg == $past(start_reg) - 8'h01)
        else $error("start temperature not lowered above target");
endmodule

/* File: hdl/fmdt_fan_mux.sv */
// Notes on behaviour
// R1: Three 8-bit target registers, one per channel, reset to the 100 C code.
// R2: Dynamic mode moves each channel start temperature to hold its target.
// R3: Each thermal zone is adjusted on its own toward its own target.
// R4: Temperature below low limit sets a status flag, alert if enabled.
// R5: Temperature above high limit sets a status flag, alert if enabled.
// R6: Above the overlimit threshold the fan outputs can run at full duty.
// R7: Automatic mode turns a fan on once temperature reaches start temperature.
// R8: Per-channel slope span sets how duty rises above the start temperature.
// R9: Bits 7 to 5 of each output configuration register select its behaviour.
// R10: Codes 000, 001, 010 select remote 1, local, remote 2 control.
// R11: Code 101 drives the faster of local and remote 2 speeds.
// R12: Code 110 drives the fastest of all three channel speeds.
// R13: Code 011 holds the output at full speed.
// R14: Code 100 disables the output and is the reset behaviour.
// R15: Code 111 makes duty registers writable and drives outputs from them.
// R16: One channel may control several outputs at once.
// R17: Software reassigns the shared pins: output 2 or alert, tach or overlimit, voltage or VID.
// R18: Software sets the automatic parameters before enabling dynamic mode.
// R19: Start temperatures are 8-bit, 1 C steps, twos complement or offset-64.
// R20: A fan turns off only below start temperature minus hysteresis; where that subtraction wraps, the code turns it off below start.
// R21: Fastest codes compute each channel duty separately and drive the largest.
// R22: Dynamic mode lowers start while above target, raises it back while below.
module fmdt_fan_mux #(
    parameter int DYN_STEP_CYCLES = fmdt_pkg::DYN_STEP_CYC,
    parameter int N_CHAN = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] temp_remote1,
    input wire logic [7:0] temp_local,
    input wire logic [7:0] temp_remote2,
    input wire logic [7:0] overlimit_threshold,
    input wire fmdt_pkg::fmdt_lim_s lim_remote1,
    input wire fmdt_pkg::fmdt_lim_s lim_local,
    input wire fmdt_pkg::fmdt_lim_s lim_remote2,
    input wire logic thermal_overlimit_pin_n,
    output logic fan_drive_output_1,
    output logic shared_pin2_out,
    output logic shared_pin2_oe_n,
    output logic fan_drive_output_3,
    output logic fan_speed_input_4_is_overlimit,
    output logic volt_is_vid
);
    logic [7:0] target_reg [N_CHAN];
    logic [7:0] min_duty_reg [N_CHAN];
    logic [7:0] cfg_reg [N_CHAN];
    logic [7:0] manual_reg [N_CHAN];
    logic [7:0] misc_reg;
    logic [5:0] status_reg;
    logic [7:0] rdata_reg;
    logic [7:0] pwm_cnt_reg;
    localparam int SYNC_N = fmdt_pkg::SYNC_STAGES;
    logic [N_CHAN-1:0] pwm_out_reg;
    logic [31:0] step_cnt_reg;
    logic dyn_step;
    logic [SYNC_N-1:0] ovl_sync_reg;
    logic [7:0] temps [N_CHAN];
    fmdt_pkg::fmdt_lim_s lims [N_CHAN];
    logic [7:0] chan_duty [N_CHAN][N_CHAN];
    logic [7:0] chan_start [N_CHAN];
    logic [7:0] start_all [N_CHAN][N_CHAN];
    logic below_all [N_CHAN][N_CHAN];
    logic above_all [N_CHAN][N_CHAN];
    logic [N_CHAN-1:0] below, above;
    logic [7:0] out_duty [N_CHAN];
    logic overlimit;
    logic twos;

    assign temps[0] = temp_remote1;
    assign temps[1] = temp_local;
    assign temps[2] = temp_remote2;
    assign lims[0] = lim_remote1;
    assign lims[1] = lim_local;
    assign lims[2] = lim_remote2;
    assign twos = misc_reg[fmdt_pkg::MISC_TWOS];

    function automatic logic [7:0] max2(input logic [7:0] a, input logic [7:0] b);
        max2 = (a > b) ? a : b;
    endfunction

    function automatic fmdt_pkg::fmdt_bhv_e bhv_of(input logic [7:0] cfg);
        bhv_of = fmdt_pkg::fmdt_bhv_e'(cfg[fmdt_pkg::BHV_MSB:fmdt_pkg::BHV_LSB]); // R9
    endfunction

    // Overlimit pin crosses in from outside
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ovl_sync_reg <= '0;
        end else if (ce) begin
            ovl_sync_reg <= {ovl_sync_reg[SYNC_N-2:0], ~thermal_overlimit_pin_n};
        end
    end

    always_comb begin
        overlimit = 1'b0;
        for (int i = 0; i < N_CHAN; i++) begin
            if ((temps[i] ^ {twos, 7'h00}) >= (overlimit_threshold ^ {twos, 7'h00})) begin
                overlimit = 1'b1;
            end
        end
        if (misc_reg[fmdt_pkg::MISC_PIN_OVL] && ovl_sync_reg[SYNC_N-1]) begin
            overlimit = 1'b1;
        end
        overlimit = overlimit && misc_reg[fmdt_pkg::MISC_OVL_FULL];
    end

    // Interval between dynamic start-temperature steps
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            step_cnt_reg <= '0;
        end else if (ce) begin
            if (step_cnt_reg >= 32'(DYN_STEP_CYCLES - 1)) begin
                step_cnt_reg <= '0;
            end else begin
                step_cnt_reg <= step_cnt_reg + 32'd1;
            end
        end
    end
    assign dyn_step = (step_cnt_reg >= 32'(DYN_STEP_CYCLES - 1));

    // Each channel computes its duty per output, with that output's minimum
    genvar c, o;
    generate
        for (c = 0; c < N_CHAN; c++) begin : g_chan
            for (o = 0; o < N_CHAN; o++) begin : g_out
                fmdt_chan u_chan (
                    .core_clk(core_clk),
                    .rst(rst),
                    .ce(ce),
                    .twos(twos),
                    .temp(temps[c]),
                    .start_wr(reg_wr && reg_addr == fmdt_pkg::OFS_START_R1 + 8'(c)),
                    .start_wdata(reg_wdata),
                    .target(target_reg[c]),
                    .lim(lims[c]),
                    .min_duty(min_duty_reg[o]),
                    .dyn_en(misc_reg[fmdt_pkg::MISC_DYN_EN]), // R3
                    .dyn_step(dyn_step),
                    .duty(chan_duty[c][o]),
                    .start_now(start_all[c][o]),
                    .below_low(below_all[c][o]),
                    .above_high(above_all[c][o])
                );
            end
            assign chan_start[c] = start_all[c][0];
            assign below[c] = below_all[c][0];
            assign above[c] = above_all[c][0];
        end

        for (o = 0; o < N_CHAN; o++) begin : g_mux
            always_comb begin
                case (bhv_of(cfg_reg[o]))
                    fmdt_pkg::BHV_REMOTE1: out_duty[o] = chan_duty[0][o]; // R10 R16
                    fmdt_pkg::BHV_LOCAL: out_duty[o] = chan_duty[1][o]; // R10
                    fmdt_pkg::BHV_REMOTE2: out_duty[o] = chan_duty[2][o]; // R10
                    fmdt_pkg::BHV_FULL: out_duty[o] = fmdt_pkg::FULL_DUTY; // R13
                    fmdt_pkg::BHV_OFF: out_duty[o] = 8'h00; // R14
                    fmdt_pkg::BHV_FAST_LR2: out_duty[o] = max2(chan_duty[1][o], chan_duty[2][o]); // R11 R21
                    fmdt_pkg::BHV_FAST_ALL: out_duty[o] = max2(chan_duty[0][o],
                        max2(chan_duty[1][o], chan_duty[2][o])); // R12 R21
                    default: out_duty[o] = manual_reg[o]; // R15
                endcase
                if (overlimit && bhv_of(cfg_reg[o]) != fmdt_pkg::BHV_OFF) begin
                    out_duty[o] = fmdt_pkg::FULL_DUTY; // R6
                end
            end

            AST_FULL_CODE: assert property (@(posedge core_clk) disable iff (rst) // R13
                ce && bhv_of(cfg_reg[o]) == fmdt_pkg::BHV_FULL |=> pwm_out_reg[o])
                else $error("full speed output not held high");
            AST_OFF_CODE: assert property (@(posedge core_clk) disable iff (rst) // R14
                ce && bhv_of(cfg_reg[o]) == fmdt_pkg::BHV_OFF |=> !pwm_out_reg[o])
                else $error("disabled output drove high");
            AST_FAST_ALL: assert property (@(posedge core_clk) disable iff (rst) // R12
                bhv_of(cfg_reg[o]) == fmdt_pkg::BHV_FAST_ALL && !overlimit
                |-> out_duty[o] >= chan_duty[0][o] && out_duty[o] >= chan_duty[1][o]
                && out_duty[o] >= chan_duty[2][o])
                else $error("fastest duty below a channel duty");
            AST_FAST_LR2: assert property (@(posedge core_clk) disable iff (rst) // R11
                bhv_of(cfg_reg[o]) == fmdt_pkg::BHV_FAST_LR2 && !overlimit
                |-> out_duty[o] == max2(chan_duty[1][o], chan_duty[2][o]))
                else $error("local and remote 2 maximum wrong");
            AST_MANUAL: assert property (@(posedge core_clk) disable iff (rst) // R15
                bhv_of(cfg_reg[o]) == fmdt_pkg::BHV_MANUAL && !overlimit
                |-> out_duty[o] == manual_reg[o])
                else $error("manual duty not driven from register");
        end
    endgenerate

    // One process owns all drive bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwm_out_reg <= '0;
        end else if (ce) begin
            for (int i = 0; i < N_CHAN; i++) begin
                pwm_out_reg[i] <= (out_duty[i] == fmdt_pkg::FULL_DUTY)
                    || (pwm_cnt_reg < out_duty[i]);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pwm_cnt_reg <= 8'h00;
        end else if (ce) begin
            pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
        end
    end

    // Register writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N_CHAN; i++) begin
                target_reg[i] <= fmdt_pkg::RST_TARGET; // R1
                min_duty_reg[i] <= fmdt_pkg::RST_MIN_DUTY;
                cfg_reg[i] <= fmdt_pkg::RST_CFG; // R14
                manual_reg[i] <= fmdt_pkg::RST_DUTY;
            end
            misc_reg <= fmdt_pkg::RST_MISC;
        end else if (ce && reg_wr) begin
            for (int i = 0; i < N_CHAN; i++) begin
                if (reg_addr == fmdt_pkg::OFS_TARGET_R1 + 8'(i)) begin
                    target_reg[i] <= reg_wdata; // R1
                end else if (reg_addr == fmdt_pkg::OFS_MIN_DUTY_1 + 8'(i)) begin
                    min_duty_reg[i] <= reg_wdata;
                end else if (reg_addr == fmdt_pkg::OFS_CFG_1 + 8'(i)) begin
                    cfg_reg[i] <= reg_wdata; // R9
                end else if (reg_addr == fmdt_pkg::OFS_DUTY_1 + 8'(i)
                    && bhv_of(cfg_reg[i]) == fmdt_pkg::BHV_MANUAL) begin
                    manual_reg[i] <= reg_wdata; // R15
                end
            end
            if (reg_addr == fmdt_pkg::OFS_MISC_CTRL) begin
                misc_reg <= reg_wdata; // R17
            end
        end
    end

    // Limit flags: a new event outranks a write-one clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= '0;
        end else if (ce) begin
            for (int i = 0; i < N_CHAN; i++) begin
                if (below[i]) begin
                    status_reg[i] <= 1'b1; // R4
                end else if (reg_wr && reg_addr == fmdt_pkg::OFS_STATUS && reg_wdata[i]) begin
                    status_reg[i] <= 1'b0;
                end
                if (above[i]) begin
                    status_reg[i+3] <= 1'b1; // R5
                end else if (reg_wr && reg_addr == fmdt_pkg::OFS_STATUS && reg_wdata[i+3]) begin
                    status_reg[i+3] <= 1'b0;
                end
            end
        end
    end

    // Register reads
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (ce && reg_rd) begin
            rdata_reg <= 8'h00;
            for (int i = 0; i < N_CHAN; i++) begin
                if (reg_addr == fmdt_pkg::OFS_TARGET_R1 + 8'(i)) begin
                    rdata_reg <= target_reg[i];
                end else if (reg_addr == fmdt_pkg::OFS_MIN_DUTY_1 + 8'(i)) begin
                    rdata_reg <= min_duty_reg[i];
                end else if (reg_addr == fmdt_pkg::OFS_CFG_1 + 8'(i)) begin
                    rdata_reg <= cfg_reg[i];
                end else if (reg_addr == fmdt_pkg::OFS_DUTY_1 + 8'(i)) begin
                    rdata_reg <= out_duty[i];
                end else if (reg_addr == fmdt_pkg::OFS_START_R1 + 8'(i)) begin
                    rdata_reg <= chan_start[i];
                end
            end
            if (reg_addr == fmdt_pkg::OFS_MISC_CTRL) begin
                rdata_reg <= misc_reg;
            end else if (reg_addr == fmdt_pkg::OFS_STATUS) begin
                rdata_reg <= {2'b00, status_reg};
            end
        end
    end
    assign reg_rdata = rdata_reg;

    // Shared pin: output 2 drive or open-drain alert
    always_comb begin
        if (misc_reg[fmdt_pkg::MISC_PIN2_ALERT]) begin
            shared_pin2_out = 1'b0;
            shared_pin2_oe_n = !(misc_reg[fmdt_pkg::MISC_ALERT_EN] && (status_reg != '0)); // R4 R5
        end else begin
            shared_pin2_out = pwm_out_reg[1]; // R17
            shared_pin2_oe_n = 1'b0;
        end
    end

    assign fan_drive_output_1 = pwm_out_reg[0];
    assign fan_drive_output_3 = pwm_out_reg[2];
    assign fan_speed_input_4_is_overlimit = misc_reg[fmdt_pkg::MISC_PIN_OVL]; // R17
    assign volt_is_vid = misc_reg[fmdt_pkg::MISC_PIN_VID]; // R17

    AST_LOW_FLAG: assert property (@(posedge core_clk) disable iff (rst) // R4
        ce && below[0] |=> status_reg[0])
        else $error("low limit flag not set");
    AST_HIGH_FLAG: assert property (@(posedge core_clk) disable iff (rst) // R5
        ce && above[2] |=> status_reg[5])
        else $error("high limit flag not set");
    AST_OVERLIMIT: assert property (@(posedge core_clk) disable iff (rst) // R6
        ce && overlimit && bhv_of(cfg_reg[0]) != fmdt_pkg::BHV_OFF |=> fan_drive_output_1)
        else $error("overlimit did not force full duty");
endmodule

/* File: hdl/fmdt_pkg.sv */
package fmdt_pkg;

    // Register offsets
    localparam logic [7:0] OFS_DUTY_1 = 8'h30;
    localparam logic [7:0] OFS_DUTY_2 = 8'h31;
    localparam logic [7:0] OFS_DUTY_3 = 8'h32;
    localparam logic [7:0] OFS_TARGET_R1 = 8'h33;
    localparam logic [7:0] OFS_TARGET_LOC = 8'h34;
    localparam logic [7:0] OFS_TARGET_R2 = 8'h35;
    localparam logic [7:0] OFS_MISC_CTRL = 8'h40;
    localparam logic [7:0] OFS_STATUS = 8'h41;
    localparam logic [7:0] OFS_CFG_1 = 8'h5C;
    localparam logic [7:0] OFS_CFG_2 = 8'h5D;
    localparam logic [7:0] OFS_CFG_3 = 8'h5E;
    localparam logic [7:0] OFS_MIN_DUTY_1 = 8'h64;
    localparam logic [7:0] OFS_START_R1 = 8'h67;

    // Field positions
    localparam int BHV_MSB = 7;
    localparam int BHV_LSB = 5;
    localparam int MISC_TWOS = 0;
    localparam int MISC_DYN_EN = 1;
    localparam int MISC_ALERT_EN = 2;
    localparam int MISC_PIN2_ALERT = 3;
    localparam int MISC_OVL_FULL = 4;
    localparam int MISC_PIN_OVL = 5;
    localparam int MISC_PIN_VID = 6;

    // Values after reset, and the full duty code
    localparam logic [7:0] RST_TARGET = 8'hA4;
    localparam logic [7:0] RST_START = 8'h9A;
    localparam logic [7:0] RST_MIN_DUTY = 8'h80;
    localparam logic [7:0] RST_CFG = 8'h80;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [7:0] RST_MISC = 8'h00;
    localparam logic [7:0] FULL_DUTY = 8'hFF;

    // Timing
    localparam int CLK_MHZ = 25;
    localparam int DYN_STEP_US = 1000;
    localparam int DYN_STEP_CYC = DYN_STEP_US * CLK_MHZ;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        BHV_REMOTE1 = 3'b000,
        BHV_LOCAL = 3'b001,
        BHV_REMOTE2 = 3'b010,
        BHV_FULL = 3'b011,
        BHV_OFF = 3'b100,
        BHV_FAST_LR2 = 3'b101,
        BHV_FAST_ALL = 3'b110,
        BHV_MANUAL = 3'b111
    } fmdt_bhv_e;

    typedef struct packed {
        logic [7:0] low_temperature_limit;
        logic [7:0] high_temperature_limit;
        logic [7:0] turn_off_hysteresis;
        logic [7:0] dynamic_floor;
        logic [2:0] control_slope_span;
    } fmdt_lim_s;

endpackage

/* File: sim/fmdt_fan_model.sv */
module fmdt_fan_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic pwm_in,
    output logic [8:0] duty_meas
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic [8:0] highs;
    // High cycles counted over every window of one drive period
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            highs <= 9'h000;
            duty_meas <= 9'h000;
        end else begin
            cnt <= cnt + 8'h01;
            if (cnt == 8'hFF) begin
                duty_meas <= highs + {8'h00, pwm_in};
                highs <= 9'h000;
            end else begin
                highs <= highs + {8'h00, pwm_in};
            end
        end
    end
endmodule

/* File: sim/fmdt_fan_mux_tb_top.sv */
module fmdt_fan_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst, reg_wr, reg_rd, ovl_n, ce;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, t_r1, t_loc, t_r2, ovl_th;
    logic out1, p2_out, p2_oe_n, out3, tach_ovl, vid, p2_wire;
    fmdt_pkg::fmdt_lim_s lim;
    logic [8:0] m1, m2, m3;
    int err_count, cmp_count;
    assign lim = '{8'h60, 8'hB0, 8'h04, 8'h80, 3'h0};
    // Pin 2 idles high through its pull-up when not driven
    assign p2_wire = p2_oe_n ? 1'b1 : p2_out;
    fmdt_fan_mux #(.DYN_STEP_CYCLES(4)) DUT (.core_clk(core_clk), .rst(rst), .ce(ce),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .temp_remote1(t_r1), .temp_local(t_loc), .temp_remote2(t_r2),
        .overlimit_threshold(ovl_th), .lim_remote1(lim), .lim_local(lim), .lim_remote2(lim),
        .thermal_overlimit_pin_n(ovl_n), .fan_drive_output_1(out1), .shared_pin2_out(p2_out),
        .shared_pin2_oe_n(p2_oe_n), .fan_drive_output_3(out3), .fan_speed_input_4_is_overlimit(tach_ovl),
        .volt_is_vid(vid));
    fmdt_fan_model FAN1 (.core_clk(core_clk), .rst(rst), .pwm_in(out1), .duty_meas(m1));
    fmdt_fan_model FAN2 (.core_clk(core_clk), .rst(rst), .pwm_in(p2_wire), .duty_meas(m2));
    fmdt_fan_model FAN3 (.core_clk(core_clk), .rst(rst), .pwm_in(out3), .duty_meas(m3));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        chk($sformatf("reg %h", a), {1'b0, exp}, {1'b0, reg_rdata});
    endtask
    task automatic set_bhv(input logic [2:0] code);
        for (int i = 0; i < 3; i++) wr(fmdt_pkg::OFS_CFG_1 + 8'(i), {code, 5'h00});
    endtask
    task automatic meas(input int e1, input int e2, input int e3);
        repeat (600) @(negedge core_clk);
        chk("fan 1", 9'(e1), m1);
        chk("fan 2", 9'(e2), m2);
        chk("fan 3", 9'(e3), m3);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 3; i++) begin
            rd_chk(fmdt_pkg::OFS_TARGET_R1 + 8'(i), 8'hA4);
            rd_chk(fmdt_pkg::OFS_CFG_1 + 8'(i), 8'h80);
            rd_chk(fmdt_pkg::OFS_START_R1 + 8'(i), 8'h9A);
        end
        wr(fmdt_pkg::OFS_TARGET_LOC, 8'h5A);
        rd_chk(fmdt_pkg::OFS_TARGET_LOC, 8'h5A);
        ce = 1'b0;
        wr(fmdt_pkg::OFS_TARGET_R2, 8'h11);
        ce = 1'b1;
        rd_chk(fmdt_pkg::OFS_TARGET_R2, 8'hA4);
        wr(fmdt_pkg::OFS_START_R1 + 8'h02, 8'h70);
        rd_chk(fmdt_pkg::OFS_START_R1 + 8'h02, 8'h70);
        meas(0, 0, 0);
    endtask
    task automatic t_manual;
        wr(fmdt_pkg::OFS_DUTY_1, 8'h40);
        set_bhv(3'b111);
        rd_chk(fmdt_pkg::OFS_DUTY_1, 8'h00);
        for (int i = 0; i < 3; i++) wr(fmdt_pkg::OFS_DUTY_1 + 8'(i), 8'h40 + 8'(i));
        rd_chk(fmdt_pkg::OFS_DUTY_2, 8'h41);
        rd_chk(8'h7F, 8'h00);
        meas(64, 65, 66);
    endtask
    task automatic t_mux;
        logic [2:0] code [9] = '{3'b000, 3'b001, 3'b001, 3'b010, 3'b010,
            3'b101, 3'b101, 3'b110, 3'b011};
        int hot [9] = '{0, 0, 1, 1, 2, 0, 2, 0, 3};
        int exp [9] = '{256, 0, 256, 0, 256, 0, 256, 256, 256};
        for (int k = 0; k < 9; k++) begin
            t_r1 = (hot[k] == 0) ? 8'hC0 : 8'h50;
            t_loc = (hot[k] == 1) ? 8'hC0 : 8'h50;
            t_r2 = (hot[k] == 2) ? 8'hC0 : 8'h50;
            set_bhv(code[k]);
            meas(exp[k], exp[k], exp[k]);
        end
    endtask
    task automatic t_hyst;
        set_bhv(3'b000);
        t_r1 = 8'h9A;
        meas(128, 128, 128);
        t_r1 = 8'h9B;
        meas(191, 191, 191);
        t_r1 = 8'h99;
        meas(128, 128, 128);
        t_r1 = 8'h90;
        meas(0, 0, 0);
    endtask
    task automatic t_alert;
        t_r1 = 8'h70;
        t_loc = 8'h70;
        t_r2 = 8'h70;
        wr(fmdt_pkg::OFS_STATUS, 8'h3F);
        rd_chk(fmdt_pkg::OFS_STATUS, 8'h00);
        t_r1 = 8'hC0;
        t_loc = 8'h50;
        t_r2 = 8'h50;
        rd_chk(fmdt_pkg::OFS_STATUS, 8'h0E);
        wr(fmdt_pkg::OFS_MISC_CTRL, 8'h0C);
        repeat (4) @(negedge core_clk);
        chk("alert oe_n", 9'h000, {8'h00, p2_oe_n});
        t_r1 = 8'h70;
        t_loc = 8'h70;
        t_r2 = 8'h70;
        wr(fmdt_pkg::OFS_STATUS, 8'h3F);
        repeat (4) @(negedge core_clk);
        chk("alert oe_n", 9'h001, {8'h00, p2_oe_n});
        wr(fmdt_pkg::OFS_MISC_CTRL, 8'h60);
        repeat (4) @(negedge core_clk);
        chk("pin select", 9'h003, {7'h00, tach_ovl, vid});
    endtask
    task automatic t_over;
        wr(fmdt_pkg::OFS_MISC_CTRL, 8'h10);
        ovl_th = 8'h60;
        meas(256, 256, 256);
        ovl_th = 8'hFF;
        meas(0, 0, 0);
        wr(fmdt_pkg::OFS_MISC_CTRL, 8'h30);
        ovl_n = 1'b0;
        meas(256, 256, 256);
        ovl_n = 1'b1;
        wr(fmdt_pkg::OFS_MISC_CTRL, 8'h00);
    endtask
    task automatic t_dyn;
        wr(fmdt_pkg::OFS_TARGET_R1, 8'h90);
        t_r1 = 8'hC0;
        t_loc = 8'h50;
        wr(fmdt_pkg::OFS_MISC_CTRL, 8'h02);
        repeat (300) @(negedge core_clk);
        rd_chk(fmdt_pkg::OFS_START_R1, 8'h80);
        rd_chk(fmdt_pkg::OFS_START_R1 + 8'h01, 8'h9A);
        t_r1 = 8'h50;
        repeat (300) @(negedge core_clk);
        rd_chk(fmdt_pkg::OFS_START_R1, 8'h9A);
        wr(fmdt_pkg::OFS_MISC_CTRL, 8'h00);
    endtask
    task automatic results;
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        err_count = 0;
        cmp_count = 0;
        rst = 1'b1;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        ovl_n = 1'b1;
        ovl_th = 8'hFF;
        t_r1 = 8'h50;
        t_loc = 8'h50;
        t_r2 = 8'h50;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_manual();
        t_mux();
        t_hyst();
        t_alert();
        t_over();
        t_dyn();
        results();
    end
    initial begin
        #(40 * 30000);
        err_count++;
        results();
    end
endmodule
